// *** design/ocd_regs.vh ***
`ifndef OCD_REGS_VH
`define OCD_REGS_VH
`define OCD_ERASED_BYTE      8'hFF
`define OCD_B0_WATCHDOG_RESET_ON_HALT      7
`define OCD_B0_WATCHDOG_SOFTWARE_SELECT        6
`define OCD_B0_VD_HI         4
`define OCD_B0_VD_LO         3
`define OCD_B0_READOUT       0
`define OCD_B1_PKG           7
`define OCD_B1_RESET_DELAY_SELECT          6
`define OCD_B1_OSC_HI        5
`define OCD_B1_OSC_LO        4
`define OCD_B1_RANGE_HI      3
`define OCD_B1_RANGE_LO      1
`define OCD_B1_DOUBLER_OFF   0
`define OCD_VD_OFF           2'h3
`define OCD_OSC_RESONATOR    2'h0
`define OCD_OSC_RESERVED     2'h1
`define OCD_OSC_INTERNAL_RC  2'h2
`define OCD_OSC_EXTERNAL     2'h3
`define OCD_RANGE_MEDIUM_PWR 3'h1
`define OCD_DELAY_LONG       13'h1000
`define OCD_DELAY_SHORT      13'h0100
`define OCD_PADS_ALL         8'hFF
`define OCD_PADS_32PIN_A     8'h3F
`define OCD_PADS_32PIN_B     8'h0F
`define OCD_PADS_32PIN_C     8'hFF
`define OCD_PADS_32PIN_D     8'h3F
`endif

// *** design/ocd_option_decoder.v ***
`timescale 1ns/100ps
`include "ocd_regs.vh"
module ocd_option_decoder #(
   parameter [0:0] MASK_VARIANT = 1'b0,         // 1: values fixed at manufacture
   parameter [7:0] MASK_BYTE0   = 8'hFF,        // hard-wired byte 0
   parameter [7:0] MASK_BYTE1   = 8'hFF         // hard-wired byte 1
) (
   input  wire        CLK,                      // 50 MHz system clock
   input  wire        RST_N,                    // async reset, active low
   input  wire        PROG_MODE,                // programming mode pin level
   input  wire        PROG_WR,                  // write strobe from programmer
   input  wire        PROG_ERASE,               // erase request for option bytes
   input  wire        PROG_SEL,                 // 0 byte zero, 1 byte one
   input  wire [7:0]  PROG_WDATA,               // write data
   output reg  [7:0]  PROG_RDATA,               // read data, zero outside prog mode
   output reg         PROG_BUSY,                // erase in progress
   output reg         MEM_ERASE_REQ,            // wipe user program memory
   input  wire        MEM_ERASE_DONE,           // program memory wipe finished
   output reg         WATCHDOG_RESET_ON_HALT,   // halt while active resets
   output reg         WATCHDOG_SOFTWARE_SELECT, // 1: software enables watchdog
   output reg         VOLTAGE_DETECT_ENABLE,    // both detectors on
   output reg  [1:0]  VOLTAGE_DETECT_THRESHOLD, // 0 high, 1 medium, 2 low
   output reg         READOUT_PROTECTION,       // 1: protection active
   output reg         PACKAGE_SELECT,           // 1: 44 pin bonding
   output reg  [31:0] PAD_PULLUP_FORCE,         // unbonded pads held pull-up inputs
   output reg  [12:0] RESET_DELAY_CYCLES,       // cpu cycles of reset phase
   output reg  [1:0]  CLOCK_SOURCE_TYPE,        // main clock source
   output reg  [2:0]  OSCILLATOR_CURRENT_RANGE, // resonator current range
   output reg         DOUBLER_ENABLE            // clock doubler on
);

   // erase sequencer states
   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_WIPE  = 2'h1;
   localparam [1:0] ST_CLEAR = 2'h2;

   reg        rst_meta_reg;                     // reset release stage one
   reg        rst_sync_reg;                     // synchronised reset, active low
   reg        mode_meta_reg;                    // programming mode stage one
   reg        mode_reg;                         // programming mode, synchronised
   reg        done_meta_reg;                    // wipe done stage one
   reg        done_reg;                         // wipe done, synchronised
   reg [7:0]  store0_reg;                       // non-volatile byte zero
   reg [7:0]  store1_reg;                       // non-volatile byte one
   reg [1:0]  state_reg;                        // erase sequencer
   reg        loaded_reg;                       // settings captured since reset
   wire [7:0] src0;                             // byte zero source
   wire [7:0] src1;                             // byte one source
   wire [1:0] osc_type;                         // clock source field
   wire       protect_stored;                   // protection in stored byte

   // reset release through two flops
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // mode pin and wipe-done inputs cross through two flops
   always @(posedge CLK or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         mode_meta_reg <= 1'b0;
         mode_reg      <= 1'b0;
         done_meta_reg <= 1'b0;
         done_reg      <= 1'b0;
      end else begin
         mode_meta_reg <= PROG_MODE;
         mode_reg      <= mode_meta_reg;
         done_meta_reg <= MEM_ERASE_DONE;
         done_reg      <= done_meta_reg;
      end
   end

   // mask variants ignore the storage entirely
   assign src0 = MASK_VARIANT ? MASK_BYTE0 : store0_reg;
   assign src1 = MASK_VARIANT ? MASK_BYTE1 : store1_reg;
   assign protect_stored = ~src0[`OCD_B0_READOUT];

   // option storage: only written in programming mode
   // note: storage model resets to erased; a real cell keeps its value over reset
   always @(posedge CLK or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         store0_reg    <= `OCD_ERASED_BYTE;
         store1_reg    <= `OCD_ERASED_BYTE;
         state_reg     <= ST_IDLE;
         MEM_ERASE_REQ <= 1'b0;
         PROG_BUSY     <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (mode_reg && PROG_ERASE) begin
                  PROG_BUSY <= 1'b1;
                  if (protect_stored) begin
                     // program memory must go before the options
                     MEM_ERASE_REQ <= 1'b1;
                     state_reg     <= ST_WIPE;
                  end else begin
                     state_reg <= ST_CLEAR;
                  end
               end else if (mode_reg && PROG_WR) begin
                  if (PROG_SEL)
                     store1_reg <= PROG_WDATA;
                  else
                     store0_reg <= PROG_WDATA;
               end
            end
            ST_WIPE: begin
               // hold the request until the memory reports done
               if (done_reg) begin
                  MEM_ERASE_REQ <= 1'b0;
                  state_reg     <= ST_CLEAR;
               end
            end
            ST_CLEAR: begin
               store0_reg <= `OCD_ERASED_BYTE;
               store1_reg <= `OCD_ERASED_BYTE;
               PROG_BUSY  <= 1'b0;
               state_reg  <= ST_IDLE;
            end
            default: begin
               state_reg     <= ST_IDLE;
               MEM_ERASE_REQ <= 1'b0;
               PROG_BUSY     <= 1'b0;
            end
         endcase
      end
   end

   // read port, invisible outside programming mode
   always @(posedge CLK or negedge rst_sync_reg) begin
      if (!rst_sync_reg)
         PROG_RDATA <= 8'h00;
      else if (mode_reg)
         PROG_RDATA <= PROG_SEL ? src1 : src0;
      else
         PROG_RDATA <= 8'h00;
   end

   // clock source field of byte one, shared by several decodes
   assign osc_type = src1[`OCD_B1_OSC_HI:`OCD_B1_OSC_LO];

   // next values of the decoded settings; they are worked out all the
   // time from the source bytes but only reach the outputs at capture
   reg        halt_reset_next;                  // watchdog reset on halt
   reg        sw_watchdog_next;                 // software watchdog select
   reg        vd_enable_next;                   // both detectors on
   reg [1:0]  vd_threshold_next;                // detector threshold code
   reg        protect_next;                     // readout protection active
   reg        package_next;                     // 44 pin bonding
   reg [31:0] pullup_next;                      // pads held pull-up inputs
   reg [12:0] delay_next;                       // reset phase length
   reg [1:0]  osc_type_next;                    // main clock source
   reg [2:0]  range_next;                       // oscillator current range
   reg        doubler_next;                     // clock doubler on
   wire [1:0] vd_field;                         // voltage detection field
   wire [2:0] range_field;                      // oscillator range field

   // raw fields picked out of the source bytes
   assign vd_field    = src0[`OCD_B0_VD_HI:`OCD_B0_VD_LO];
   assign range_field = src1[`OCD_B1_RANGE_HI:`OCD_B1_RANGE_LO];

   // watchdog options are single bits, passed as stored
   always @* begin
      // 1: entering halt while the watchdog runs gives a reset
      halt_reset_next  = src0[`OCD_B0_WATCHDOG_RESET_ON_HALT];
      // 0: watchdog always on, 1: left to software
      sw_watchdog_next = src0[`OCD_B0_WATCHDOG_SOFTWARE_SELECT];
   end

   // voltage detectors: one field both enables and picks the level
   always @* begin
      // threshold code is kept even when off, so the setting reads back
      vd_threshold_next = vd_field;
      case (vd_field)
         `OCD_VD_OFF: begin
            // both detectors switched off
            vd_enable_next = 1'b0;
         end
         default: begin
            // highest, medium or lowest threshold, detectors on
            vd_enable_next = 1'b1;
         end
      endcase
   end

   // protection is active low in storage, so an erased part is open
   always @* begin
      protect_next = protect_stored;
   end

   // package bonding variant; only the pad pull-ups depend on it here
   always @* begin
      package_next = src1[`OCD_B1_PKG];
   end

   // pads of each port that the small package leaves without a pin;
   // a set bit in a bonded mask means the pad reaches a pin
   always @* begin
      if (package_next) begin
         // every pad is bonded on the large package
         pullup_next = 32'h0000_0000;
      end else begin
         // unbonded pads are forced to pull-up inputs so they never float
         pullup_next[7:0]   = ~`OCD_PADS_32PIN_A;
         pullup_next[15:8]  = ~`OCD_PADS_32PIN_B;
         pullup_next[23:16] = ~`OCD_PADS_32PIN_C;
         pullup_next[31:24] = ~`OCD_PADS_32PIN_D;
      end
   end

   // reset phase length, also applied on exit from halt
   always @* begin
      if (src1[`OCD_B1_RESET_DELAY_SELECT])
         delay_next = `OCD_DELAY_SHORT;
      else
         delay_next = `OCD_DELAY_LONG;
   end

   // main clock source and the oscillator current range that goes with it
   always @* begin
      // the source code itself is passed on unchanged
      osc_type_next = osc_type;
      case (osc_type)
         `OCD_OSC_RESONATOR: begin
            // resonator: the field sets the current source
            range_next = range_field;
         end
         `OCD_OSC_INTERNAL_RC: begin
            // the rc oscillator ignores the range; passing the field keeps
            // the logic small at the cost of a meaningless value here
            range_next = range_field;
         end
         `OCD_OSC_EXTERNAL: begin
            // external source: forced to medium power
            range_next = `OCD_RANGE_MEDIUM_PWR;
         end
         default: begin
            // reserved code: nothing is forced, the field stands
            range_next = range_field;
         end
      endcase
   end

   // clock doubler bit is active low in storage
   always @* begin
      // a programmer must pair it with the medium power range only
      doubler_next = ~src1[`OCD_B1_DOUBLER_OFF];
   end

   // settings captured once after reset then frozen, so later
   // programming never disturbs a running part
   // limitation: new byte values take effect only after the next reset
   always @(posedge CLK or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         // while in reset the outputs show what an erased part decodes to
         loaded_reg               <= 1'b0;
         WATCHDOG_RESET_ON_HALT   <= 1'b1;
         WATCHDOG_SOFTWARE_SELECT <= 1'b1;
         VOLTAGE_DETECT_ENABLE    <= 1'b0;
         VOLTAGE_DETECT_THRESHOLD <= `OCD_VD_OFF;
         READOUT_PROTECTION       <= 1'b0;
         PACKAGE_SELECT           <= 1'b1;
         PAD_PULLUP_FORCE         <= 32'h0000_0000;
         RESET_DELAY_CYCLES       <= `OCD_DELAY_SHORT;
         CLOCK_SOURCE_TYPE        <= `OCD_OSC_EXTERNAL;
         OSCILLATOR_CURRENT_RANGE <= `OCD_RANGE_MEDIUM_PWR;
         DOUBLER_ENABLE           <= 1'b0;
      end else if (!loaded_reg) begin
         // first edge out of reset: take every setting at once
         loaded_reg               <= 1'b1;
         WATCHDOG_RESET_ON_HALT   <= halt_reset_next;
         WATCHDOG_SOFTWARE_SELECT <= sw_watchdog_next;
         VOLTAGE_DETECT_ENABLE    <= vd_enable_next;
         VOLTAGE_DETECT_THRESHOLD <= vd_threshold_next;
         READOUT_PROTECTION       <= protect_next;
         PACKAGE_SELECT           <= package_next;
         PAD_PULLUP_FORCE         <= pullup_next;
         RESET_DELAY_CYCLES       <= delay_next;
         CLOCK_SOURCE_TYPE        <= osc_type_next;
         OSCILLATOR_CURRENT_RANGE <= range_next;
         DOUBLER_ENABLE           <= doubler_next;
      end
      // after capture nothing changes until the next reset
   end

endmodule // ocd_option_decoder

// *** bench/ocd_option_decoder_chk.sv ***
`timescale 1ns/100ps
module ocd_option_decoder_chk (
   input logic        CLK,                      // system clock
   input logic        RST_N,                    // raw reset, active low
   input logic        PROG_MODE,                // programming mode level
   input logic [7:0]  PROG_RDATA,               // read data
   input logic        PROG_BUSY,                // erase in progress
   input logic        MEM_ERASE_REQ,            // wipe request
   input logic        MEM_ERASE_DONE,           // wipe finished
   input logic        READOUT_PROTECTION,       // protection active
   input logic        PACKAGE_SELECT,           // 44 pin bonding
   input logic [31:0] PAD_PULLUP_FORCE,         // forced pull-up pads
   input logic [12:0] RESET_DELAY_CYCLES,       // reset phase length
   input logic [1:0]  CLOCK_SOURCE_TYPE,        // main clock source
   input logic [2:0]  OSCILLATOR_CURRENT_RANGE, // current range
   input logic        DOUBLER_ENABLE            // clock doubler
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   logic [2:0] age_reg; // edges since release, saturating
   // pad, delay and hold checks only judge settings once the capture has surely happened
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) age_reg <= 3'h0;
      else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
   end
   sequence mode_off;
      !PROG_MODE [*4];
   endsequence
   sequence wipe_done;
      $rose(MEM_ERASE_DONE) && MEM_ERASE_REQ;
   endsequence
   rdata_when_off_a: assert property (mode_off |=> PROG_RDATA == 8'h00)
      else $error("read data seen outside programming mode");
   req_needs_busy_a: assert property (MEM_ERASE_REQ |-> PROG_BUSY)
      else $error("wipe request without busy");
   req_holds_a: assert property (MEM_ERASE_REQ && !MEM_ERASE_DONE |=> MEM_ERASE_REQ)
      else $error("wipe request dropped early");
   req_release_a: assert property (wipe_done |-> ##[1:4] !MEM_ERASE_REQ)
      else $error("wipe request not released");
   quick_erase_a: assert property ($rose(PROG_BUSY) && !MEM_ERASE_REQ |=> !PROG_BUSY)
      else $error("unprotected erase too long");
   busy_end_a: assert property ($fell(MEM_ERASE_REQ) |=> !PROG_BUSY)
      else $error("busy after wipe");
   ext_range_a: assert property (CLOCK_SOURCE_TYPE == 2'h3 |-> OSCILLATOR_CURRENT_RANGE == 3'h1)
      else $error("external source range not forced");
   pad_force_a: assert property (age_reg == 3'h7 |->
      PAD_PULLUP_FORCE == (PACKAGE_SELECT ? 32'h0 : 32'hC000F0C0))
      else $error("unbonded pads wrong");
   delay_code_a: assert property (age_reg == 3'h7 |-> RESET_DELAY_CYCLES inside {13'h1000, 13'h0100})
      else $error("reset delay not a legal length");
   settings_hold_a: assert property (age_reg == 3'h7 |=> $stable({READOUT_PROTECTION,
      PACKAGE_SELECT, RESET_DELAY_CYCLES, CLOCK_SOURCE_TYPE, DOUBLER_ENABLE}))
      else $error("settings changed after capture");
endmodule // ocd_option_decoder_chk
bind ocd_option_decoder ocd_option_decoder_chk u_chk (.CLK(CLK), .RST_N(RST_N),
   .PROG_MODE(PROG_MODE), .PROG_RDATA(PROG_RDATA), .PROG_BUSY(PROG_BUSY),
   .MEM_ERASE_REQ(MEM_ERASE_REQ), .MEM_ERASE_DONE(MEM_ERASE_DONE),
   .READOUT_PROTECTION(READOUT_PROTECTION), .PACKAGE_SELECT(PACKAGE_SELECT),
   .PAD_PULLUP_FORCE(PAD_PULLUP_FORCE), .RESET_DELAY_CYCLES(RESET_DELAY_CYCLES),
   .CLOCK_SOURCE_TYPE(CLOCK_SOURCE_TYPE), .OSCILLATOR_CURRENT_RANGE(OSCILLATOR_CURRENT_RANGE),
   .DOUBLER_ENABLE(DOUBLER_ENABLE));

// *** bench/ocd_prog_tool.sv ***
`timescale 1ns/100ps
module ocd_prog_tool (
   input  wire logic  clk,   // system clock
   input  wire logic  req,   // wipe request
   output logic       wr,    // write strobe
   output logic       ers,   // option erase
   output logic       sel,   // byte select
   output logic [7:0] wdata, // write data
   output logic       done   // wipe finished
);
   logic [2:0] wait_reg; // wipe is slow on purpose
   initial begin
      wr = 1'b0;
      ers = 1'b0;
      sel = 1'b0;
      wdata = 8'h00;
      done = 1'b0;
   end
   // done stays up until the request drops
   always @(negedge clk) begin
      if (!req) begin
         wait_reg <= 3'h0;
         done <= 1'b0;
      end else if (wait_reg == 3'h5) done <= 1'b1;
      else wait_reg <= wait_reg + 3'h1;
   end
   // callers keep reserved bits and legal clock pairs
   task automatic put(input logic s, input logic [7:0] d);
      @(negedge clk);
      sel = s;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      wdata = ~d; // no stale value on a released bus
   endtask
   task automatic pick(input logic s);
      @(negedge clk);
      sel = s;
   endtask
   task automatic wipe;
      @(negedge clk);
      ers = 1'b1;
      @(negedge clk);
      ers = 1'b0;
   endtask
endmodule // ocd_prog_tool

// *** bench/ocd_option_decoder_test.sv ***
`timescale 1ns/100ps
module ocd_option_decoder_test;
   logic        clk, rst_n, mode;       // clock, reset, mode level
   logic        wr, ers, sel, done;     // partner outputs
   logic        busy, req;              // erase status
   logic [7:0]  wdata, rdata;           // data buses
   logic [57:0] da, db;                 // decoded: erased, mask-coded
   integer      miscompares, n_tests, cyc;
   localparam logic [55:0] ERASED = {3'b110, 1'b0, 1'b1, 32'h0, 13'h0100, 2'h3, 3'h1, 1'b0};
   localparam logic [57:0] MASKED = {3'b001, 2'h1, 1'b1, 1'b0, 32'hC000F0C0, 13'h1000, 2'h0,
      3'h3, 1'b1};
   ocd_prog_tool u_tool (.clk(clk), .req(req), .wr(wr), .ers(ers), .sel(sel), .wdata(wdata),
      .done(done));
   ocd_option_decoder u_dut (.CLK(clk), .RST_N(rst_n), .PROG_MODE(mode), .PROG_WR(wr),
      .PROG_ERASE(ers), .PROG_SEL(sel), .PROG_WDATA(wdata), .PROG_RDATA(rdata),
      .PROG_BUSY(busy), .MEM_ERASE_REQ(req), .MEM_ERASE_DONE(done),
      .WATCHDOG_RESET_ON_HALT(da[57]), .WATCHDOG_SOFTWARE_SELECT(da[56]),
      .VOLTAGE_DETECT_ENABLE(da[55]), .VOLTAGE_DETECT_THRESHOLD(da[54:53]),
      .READOUT_PROTECTION(da[52]), .PACKAGE_SELECT(da[51]), .PAD_PULLUP_FORCE(da[50:19]),
      .RESET_DELAY_CYCLES(da[18:6]), .CLOCK_SOURCE_TYPE(da[5:4]),
      .OSCILLATOR_CURRENT_RANGE(da[3:1]), .DOUBLER_ENABLE(da[0]));
   ocd_option_decoder #(.MASK_VARIANT(1'b1), .MASK_BYTE0(8'h2E), .MASK_BYTE1(8'h06)) u_mask (
      .CLK(clk), .RST_N(rst_n), .PROG_MODE(mode), .PROG_WR(wr), .PROG_ERASE(ers),
      .PROG_SEL(sel), .PROG_WDATA(wdata), .PROG_RDATA(), .PROG_BUSY(), .MEM_ERASE_REQ(),
      .MEM_ERASE_DONE(done), .WATCHDOG_RESET_ON_HALT(db[57]), .WATCHDOG_SOFTWARE_SELECT(db[56]),
      .VOLTAGE_DETECT_ENABLE(db[55]), .VOLTAGE_DETECT_THRESHOLD(db[54:53]),
      .READOUT_PROTECTION(db[52]), .PACKAGE_SELECT(db[51]), .PAD_PULLUP_FORCE(db[50:19]),
      .RESET_DELAY_CYCLES(db[18:6]), .CLOCK_SOURCE_TYPE(db[5:4]),
      .OSCILLATOR_CURRENT_RANGE(db[3:1]), .DOUBLER_ENABLE(db[0]));
   always #10 clk = ~clk;
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict;
      if (miscompares == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // read data follows the select after one registered edge
   task automatic rd(input logic s, input logic [7:0] exp);
      u_tool.pick(s);
      repeat (2) @(negedge clk);
      chk("read data", {56'h0, exp}, {56'h0, rdata});
   endtask
   task automatic t_decode;
      chk("erased decode", {8'h0, ERASED}, {8'h0, da[57:55], da[52:0]});
      chk("erased threshold", 64'h3, {62'h0, da[54:53]});
      chk("mask decode", {6'h0, MASKED}, {6'h0, db});
   endtask
   task automatic t_access;
      u_tool.put(1'b0, 8'h26);
      rd(1'b0, 8'h00);
      mode = 1'b1;
      repeat (3) @(negedge clk);
      rd(1'b0, 8'hFF);
      u_tool.put(1'b0, 8'h27);
      u_tool.put(1'b1, 8'h82);
      rd(1'b0, 8'h27);
      rd(1'b1, 8'h82);
   endtask
   // plain erase first, then a protected one that must wipe memory
   task automatic t_erase;
      integer n;
      logic   seen;
      u_tool.wipe;
      rd(1'b1, 8'hFF);
      u_tool.put(1'b0, 8'h26);
      u_tool.wipe;
      seen = 1'b0;
      for (n = 0; n < 40 && !(n > 1 && busy === 1'b0); n++) begin
         @(negedge clk);
         if (req === 1'b1) seen = 1'b1;
      end
      chk("wipe request", 64'h1, {63'h0, seen});
      rd(1'b0, 8'hFF);
   endtask
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      mode = 1'b0;
      miscompares = 0;
      n_tests = 0;
      cyc = 0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      t_decode;
      t_access;
      t_erase;
      t_decode;
      print_verdict;
   end
   // a hang counts as a mismatch
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         miscompares = miscompares + 1;
         print_verdict;
      end
   end
endmodule // ocd_option_decoder_test
